/* File: rtl/brsc_pkg.sv */
// Purpose: Shared constants and types of the reset/strap block
// Assumes: 125 MHz system clock
// Notes:   Config offsets are byte addresses
`default_nettype none
package brsc_pkg;
    // ==========
    // Config space
    localparam logic [7:0]  HDR_LAST_BYTE   = 8'h3F;
    localparam logic [7:0]  SEC_STATUS_OFF  = 8'h1E;
    localparam logic [7:0]  BRIDGE_CTL_OFF  = 8'h3E;
    localparam logic [7:0]  GPIO_CTL_OFF    = 8'h64;
    localparam int          SEC_RST_BIT     = 6;
    localparam int          STAT_66_BIT     = 5;
    localparam logic [15:0] BRIDGE_CTL_RST  = 16'h0000;
    localparam logic [3:0]  GPIO_OE_RST     = 4'h0;
    localparam logic [3:0]  GPIO_OUT_RST    = 4'h0;
    // ==========
    // Pin counts and timing
    localparam int          SEC_CLK_NUM     = 10;
    localparam int          GPIO_NUM        = 4;
    localparam int          CLK_PERIOD_NS   = 8;
    localparam int          EE_HALF_NS      = 1000;
    localparam int          EE_HALF_CYC     = EE_HALF_NS / CLK_PERIOD_NS;
    // ==========
    // TAP
    localparam logic [3:0]  IR_CAPTURE      = 4'h1;
    localparam logic [3:0]  IR_BYPASS       = 4'hF;
    typedef enum logic [15:0] {
        TS_RESET  = 16'h0001, TS_IDLE   = 16'h0002,
        TS_SELDR  = 16'h0004, TS_CAPDR  = 16'h0008,
        TS_SHDR   = 16'h0010, TS_EX1DR  = 16'h0020,
        TS_PAUDR  = 16'h0040, TS_EX2DR  = 16'h0080,
        TS_UPDDR  = 16'h0100, TS_SELIR  = 16'h0200,
        TS_CAPIR  = 16'h0400, TS_SHIR   = 16'h0800,
        TS_EX1IR  = 16'h1000, TS_PAUIR  = 16'h2000,
        TS_EX2IR  = 16'h4000, TS_UPDIR  = 16'h8000
    } brsc_tap_state_t;
endpackage : brsc_pkg
`default_nettype wire

/* File: rtl/brsc_mask_shift.sv */
// Purpose: Serial load of the secondary clock-disable mask
// Assumes: One bit taken per enabled cycle
// Notes:   Done drops whenever a load restarts
`default_nettype none
module brsc_mask_shift #(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_reset,
    input  wire logic             i_clk_en,
    // Stream
    input  wire logic             i_restart,
    input  wire logic             i_shift,
    input  wire logic             i_serial,
    // Result
    output logic      [WIDTH-1:0] o_mask,
    output logic                  o_done
);
    typedef struct packed {
        logic [WIDTH-1:0] sr;
        logic [4:0]       cnt;
        logic [WIDTH-1:0] mask;
        logic             done;
    } brsc_shift_st_t;
    brsc_shift_st_t q, d;

    always_comb begin
        d = q;
        if (i_shift && !q.done) begin
            d.sr = {i_serial, q.sr[WIDTH-1:1]};
            d.cnt = q.cnt + 5'h01;
            if (!i_restart && q.cnt == 5'(WIDTH - 1)) begin
                d.mask = d.sr;
                d.done = 1'b1;
            end
        end
        if (i_restart) begin
            d.cnt = 5'h00;
            d.done = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset)
            q <= '0;
        else if (i_clk_en)
            q <= d;
    end

    assign o_mask = q.mask;
    assign o_done = q.done;
endmodule : brsc_mask_shift
`default_nettype wire

/* File: rtl/brsc_tap.sv */
// Purpose: Boundary-scan TAP controller with bypass register
// Assumes: Test clock sampled as a plain synchronous input
// Notes:   Test reset clears the controller without a clock
`default_nettype none
module brsc_tap (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    input  wire logic i_clk_en,
    // Test port
    input  wire logic i_test_reset_n,
    input  wire logic i_test_clock,
    input  wire logic i_test_mode_select,
    input  wire logic i_test_data_in,
    output logic      o_test_data_out,
    output logic      o_test_data_out_en
);
    typedef struct packed {
        brsc_pkg::brsc_tap_state_t st;
        logic                      tck;
        logic [3:0]                ir_sr;
        logic [3:0]                ir;
        logic                      byp;
        logic                      tdo;
        logic                      tdo_en;
    } brsc_tap_st_t;
    localparam brsc_tap_st_t TAP_RST = '{brsc_pkg::TS_RESET, 1'b0,
        4'h0, brsc_pkg::IR_BYPASS, 1'b0, 1'b0, 1'b0};
    brsc_tap_st_t q, d;
    brsc_pkg::brsc_tap_state_t nx;

    // Next state by one-hot index; an all-zero code falls back to reset, multi-hot codes follow the highest set bit
    localparam int NX0 [16] =
        '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
    localparam int NX1 [16] =
        '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
    always_comb begin
        nx = brsc_pkg::TS_RESET;
        for (int i = 0; i < 16; i++) begin
            if (q.st[i])
                nx = brsc_pkg::brsc_tap_state_t'(16'h0001 <<
                    (i_test_mode_select ? NX1[i] : NX0[i]));
        end
    end

    always_comb begin
        d = q;
        d.tck = i_test_clock;
        if (i_test_clock && !q.tck) begin
            case (q.st)
                brsc_pkg::TS_CAPIR: d.ir_sr = brsc_pkg::IR_CAPTURE;
                brsc_pkg::TS_SHIR:  d.ir_sr = {i_test_data_in, q.ir_sr[3:1]};
                brsc_pkg::TS_CAPDR: d.byp = 1'b0;
                brsc_pkg::TS_SHDR:  d.byp = i_test_data_in;
                brsc_pkg::TS_UPDIR: d.ir = q.ir_sr;
                brsc_pkg::TS_RESET: d.ir = brsc_pkg::IR_BYPASS;
                default:            d.byp = q.byp;
            endcase
            d.st = nx;
        end
        if (!i_test_clock && q.tck) begin
            d.tdo = (q.st == brsc_pkg::TS_SHIR) ? q.ir_sr[0] : q.byp;
            d.tdo_en = (q.st == brsc_pkg::TS_SHIR) ||
                       (q.st == brsc_pkg::TS_SHDR);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_test_reset_n) begin
        if (!i_test_reset_n)
            q <= TAP_RST;
        else if (i_reset)
            q <= TAP_RST;
        else if (i_clk_en)
            q <= d;
    end

    assign o_test_data_out    = q.tdo;
    assign o_test_data_out_en = q.tdo_en;
endmodule : brsc_tap
`default_nettype wire

/* File: rtl/brsc_top.sv */
// Purpose: Reset propagation, strap and misc control of the bridge
// Assumes: All pins synchronous to i_sys_clk
// Notes:   Primary tri-state acts combinationally on the reset pin
//
// How it works
// - Primary reset drops all primary output drive at once.
// - Primary reset restores header bytes 0h-3Fh.
// - Secondary reset follows primary reset or bridge-control bit.
// - Arbiter select low: internal arbiter; high: external.
// - External mode swaps request zero and grant zero roles.
// - 66 MHz strap shows only in secondary status.
// - Clock-control strap high in D3hot enters B2.
// - In B2 all secondary clocks stop low.
// - Clock-control strap low leaves clocks running in D3hot.
// - Four GPIO pins, input-only or bidirectional by enable bits.
// - In primary reset GPIO pin 0 shifts in; the mask pin stream after release replaces it.
// - EEPROM clock runs during autoload and VPD accesses.
// - EEPROM data is one shared bidirectional pin.
// - Test reset clears the TAP without a test clock.
// - TAP state follows mode select on test clock.
// - TAP shifts test input in and test output out.
// - Mask loads after primary release while secondary reset holds.
`default_nettype none
module brsc_top #(
    parameter int CLK_NUM  = brsc_pkg::SEC_CLK_NUM,
    parameter int GPIO_W   = brsc_pkg::GPIO_NUM
) (
    // Clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset,
    input  wire logic              i_clk_en,
    // Reset pins
    input  wire logic              i_primary_reset_n,
    output logic                   o_secondary_reset_out_n,
    output logic                   o_header_defaults_load,
    // Primary side drive control
    input  wire logic              i_primary_outputs_drive,
    output logic                   o_primary_outputs_oe,
    input  wire logic              i_upstream_system_error_req,
    output logic                   o_upstream_system_error_n_o,
    output logic                   o_upstream_system_error_n_oe,
    input  wire logic              i_primary_grant_drive,
    output logic                   o_primary_grant_oe,
    // Config access
    input  wire logic              i_cfg_wr,
    input  wire logic              i_cfg_rd,
    input  wire logic [7:0]        i_cfg_addr,
    input  wire logic [31:0]       i_cfg_wdata,
    input  wire logic [3:0]        i_cfg_be,
    output logic      [31:0]       o_cfg_rdata,
    output logic                   o_cfg_rvalid,
    // Arbiter straps and pins
    input  wire logic              i_arbiter_select_n,
    input  wire logic              i_downstream_request_zero_n,
    output logic                   o_downstream_grant_zero_n,
    input  wire logic              i_internal_grant_zero_n,
    input  wire logic              i_bridge_request_n,
    output logic                   o_external_arbiter,
    output logic                   o_internal_request_zero_n,
    output logic                   o_external_grant_n,
    // Power and clocks
    input  wire logic              i_upstream_66mhz_strap,
    input  wire logic              i_bus_power_clock_ctrl_en,
    input  wire logic              i_power_state_d3hot,
    input  wire logic              i_secondary_clock_src,
    input  wire logic              i_clock_disable_serial_in,
    output logic      [CLK_NUM-1:0] o_secondary_clock,
    output logic      [CLK_NUM-1:0] o_secondary_clock_en,
    output logic                   o_bus_b2,
    // GPIO
    input  wire logic [GPIO_W-1:0] i_gpio,
    output logic      [GPIO_W-1:0] o_gpio,
    output logic      [GPIO_W-1:0] o_gpio_oe,
    // Serial EEPROM
    input  wire logic              i_eeprom_use_enable_n,
    input  wire logic              i_ee_autoload_active,
    input  wire logic              i_ee_vpd_active,
    input  wire logic              i_ee_data_drive,
    input  wire logic              i_ee_data_out,
    output logic                   o_eeprom_serial_clock,
    input  wire logic              i_eeprom_serial_io,
    output logic                   o_eeprom_serial_io_o,
    output logic                   o_eeprom_serial_io_oe,
    output logic                   o_ee_data_in,
    output logic                   o_eeprom_enabled,
    // Boundary scan
    input  wire logic              i_test_reset_n,
    input  wire logic              i_test_clock,
    input  wire logic              i_test_mode_select,
    input  wire logic              i_test_data_in,
    output logic                   o_test_data_out,
    output logic                   o_test_data_out_en
);
    // ==========
    // State
    typedef struct packed {
        logic [15:0]        bridge_ctl;
        logic [GPIO_W-1:0]  gpio_oe;
        logic [GPIO_W-1:0]  gpio_out;
        logic [GPIO_W-1:0]  gpio_in;
        logic               strap66;
        logic               b2;
        logic [CLK_NUM-1:0] clk_en;
        logic [31:0]        rdata;
        logic               rvalid;
        logic [7:0]         ee_cnt;
        logic               ee_clk;
        logic               ee_din;
    } brsc_top_st_t;
    brsc_top_st_t q, d;

    // ==========
    // Decode and helpers
    logic               prim_rst;
    logic               ee_active;
    logic               sec_rst;
    logic               mask_done;
    logic [CLK_NUM-1:0] mask;
    logic               shift_en;
    logic               shift_bit;
    logic [15:0]        sec_status;
    logic [31:0]        wmask;

    assign prim_rst  = !i_primary_reset_n;
    assign ee_active = !i_eeprom_use_enable_n &&
                       (i_ee_autoload_active || i_ee_vpd_active);

    // Secondary reset also stretched until the mask has loaded
    assign sec_rst = prim_rst ||
                     q.bridge_ctl[brsc_pkg::SEC_RST_BIT] ||
                     !mask_done;

    // Shift during primary reset from GPIO, then from mask pin
    assign shift_en  = prim_rst || (sec_rst && !mask_done);
    assign shift_bit = prim_rst ? i_gpio[0]
                                : i_clock_disable_serial_in;

    always_comb begin
        sec_status = 16'h0000;
        sec_status[brsc_pkg::STAT_66_BIT] = q.strap66;
    end

    assign wmask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}},
                    {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};

    // ==========
    // Next state
    always_comb begin
        d = q;
        d.strap66 = i_upstream_66mhz_strap;
        d.gpio_in = i_gpio;
        d.ee_din  = i_eeprom_serial_io;
        d.rvalid  = i_cfg_rd;

        // Config writes
        if (i_cfg_wr) begin
            if (i_cfg_addr[7:2] == brsc_pkg::BRIDGE_CTL_OFF[7:2]) begin
                d.bridge_ctl = (q.bridge_ctl & ~wmask[31:16]) |
                               (i_cfg_wdata[31:16] & wmask[31:16]);
            end
            if (i_cfg_addr[7:2] == brsc_pkg::GPIO_CTL_OFF[7:2]) begin
                if (i_cfg_be[0])
                    d.gpio_oe = i_cfg_wdata[GPIO_W-1:0];
                if (i_cfg_be[1])
                    d.gpio_out = i_cfg_wdata[8+GPIO_W-1:8];
            end
        end

        // Config reads
        if (i_cfg_rd) begin
            case (i_cfg_addr[7:2])
                brsc_pkg::SEC_STATUS_OFF[7:2]:
                    d.rdata = {sec_status, 16'h0000};
                brsc_pkg::BRIDGE_CTL_OFF[7:2]:
                    d.rdata = {q.bridge_ctl, 16'h0000};
                brsc_pkg::GPIO_CTL_OFF[7:2]:
                    d.rdata = {8'h00, 4'h0, q.gpio_in,
                               4'h0, q.gpio_out, 4'h0, q.gpio_oe};
                default:
                    d.rdata = 32'h0000_0000;
            endcase
        end

        // Bus power state and clock gating
        d.b2 = i_bus_power_clock_ctrl_en && i_power_state_d3hot;
        d.clk_en = ~mask & {CLK_NUM{!d.b2}};

        // EEPROM clock divider
        if (ee_active) begin
            if (q.ee_cnt == 8'(brsc_pkg::EE_HALF_CYC - 1)) begin
                d.ee_cnt = 8'h00;
                d.ee_clk = !q.ee_clk;
            end else begin
                d.ee_cnt = q.ee_cnt + 8'h01;
            end
        end else begin
            d.ee_cnt = 8'h00;
            d.ee_clk = 1'b0;
        end

        // Bridge control and GPIO registers back to defaults
        if (prim_rst) begin
            d.bridge_ctl = brsc_pkg::BRIDGE_CTL_RST;
            d.gpio_oe    = brsc_pkg::GPIO_OE_RST;
            d.gpio_out   = brsc_pkg::GPIO_OUT_RST;
        end
    end

    // ==========
    // Registers
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            q <= '0;
            q.bridge_ctl <= brsc_pkg::BRIDGE_CTL_RST;
            q.gpio_oe    <= brsc_pkg::GPIO_OE_RST;
            q.gpio_out   <= brsc_pkg::GPIO_OUT_RST;
        end else if (i_clk_en) begin
            q <= d;
        end
    end

    // ==========
    // Clock-disable mask loader
    brsc_mask_shift #(
        .WIDTH   (CLK_NUM)
    ) u_mask (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_clk_en  (i_clk_en),
        .i_restart (prim_rst),
        .i_shift   (shift_en),
        .i_serial  (shift_bit),
        .o_mask    (mask),
        .o_done    (mask_done)
    );

    // ==========
    // Boundary scan
    brsc_tap u_tap (
        .i_sys_clk          (i_sys_clk),
        .i_reset            (i_reset),
        .i_clk_en           (i_clk_en),
        .i_test_reset_n     (i_test_reset_n),
        .i_test_clock       (i_test_clock),
        .i_test_mode_select (i_test_mode_select),
        .i_test_data_in     (i_test_data_in),
        .o_test_data_out    (o_test_data_out),
        .o_test_data_out_en (o_test_data_out_en)
    );

    // ==========
    // Reset and primary drive
    assign o_secondary_reset_out_n = !sec_rst;
    assign o_header_defaults_load  = prim_rst;
    // Gated straight from the pin so release is not clock-bound
    assign o_primary_outputs_oe = i_primary_outputs_drive &&
                                  !prim_rst;
    assign o_upstream_system_error_n_o  = 1'b0;
    assign o_upstream_system_error_n_oe = i_upstream_system_error_req &&
                                          !prim_rst;
    assign o_primary_grant_oe = i_primary_grant_drive && !prim_rst;

    // ==========
    // Arbiter routing
    assign o_external_arbiter = i_arbiter_select_n;
    assign o_internal_request_zero_n =
        i_arbiter_select_n ? 1'b1 : i_downstream_request_zero_n;
    assign o_external_grant_n =
        i_arbiter_select_n ? i_downstream_request_zero_n : 1'b1;
    assign o_downstream_grant_zero_n =
        i_arbiter_select_n ? i_bridge_request_n
                           : i_internal_grant_zero_n;

    // ==========
    // Clocks and power
    assign o_secondary_clock =
        {CLK_NUM{i_secondary_clock_src}} & q.clk_en;
    assign o_secondary_clock_en = q.clk_en;
    assign o_bus_b2             = q.b2;

    // ==========
    // GPIO, released during primary reset for the mask stream
    assign o_gpio    = q.gpio_out;
    assign o_gpio_oe = prim_rst ? {GPIO_W{1'b0}} : q.gpio_oe;

    // ==========
    // EEPROM
    assign o_eeprom_serial_clock = q.ee_clk;
    assign o_eeprom_serial_io_o  = i_ee_data_out;
    assign o_eeprom_serial_io_oe = ee_active && i_ee_data_drive;
    assign o_ee_data_in          = q.ee_din;
    assign o_eeprom_enabled      = !i_eeprom_use_enable_n;
    assign o_cfg_rdata           = q.rdata;
    assign o_cfg_rvalid          = q.rvalid;
endmodule : brsc_top
`default_nettype wire

/* File: testbench/brsc_top_asserts.sv */
// Purpose: Port-level checks of the reset/strap block
// Assumes: One clock domain, sync reset high
// Notes:   Bound to brsc_top
`default_nettype none
module brsc_top_asserts #(
    parameter int CLK_NUM = 10,
    parameter int GPIO_W  = 4
) (
    // Clock and reset
    input wire logic               i_sys_clk, i_reset, i_clk_en,
    // Reset and primary drive
    input wire logic               i_primary_reset_n, o_secondary_reset_out_n,
    input wire logic               o_header_defaults_load, o_primary_outputs_oe,
    input wire logic               o_upstream_system_error_n_oe,
    input wire logic               o_primary_grant_oe,
    // Arbiter
    input wire logic               i_arbiter_select_n, o_external_arbiter,
    input wire logic               i_downstream_request_zero_n,
    input wire logic               i_bridge_request_n, o_external_grant_n,
    input wire logic               o_downstream_grant_zero_n,
    // Power, clocks, GPIO, TAP
    input wire logic               i_bus_power_clock_ctrl_en, o_bus_b2,
    input wire logic               i_power_state_d3hot,
    input wire logic [CLK_NUM-1:0] o_secondary_clock,
    input wire logic [GPIO_W-1:0]  o_gpio_oe,
    input wire logic               i_test_reset_n, o_test_data_out_en
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    // ==========
    // Reset propagation
    sequence s_pri_release;
        !i_primary_reset_n ##1 (i_primary_reset_n && i_clk_en);
    endsequence
    a_pri_drive_off: assert property (
        !i_primary_reset_n |-> o_header_defaults_load && !(o_primary_outputs_oe
        || o_upstream_system_error_n_oe || o_primary_grant_oe))
        else $error("primary side driven in reset");
    a_sec_rst_follow: assert property (
        !i_primary_reset_n |-> !o_secondary_reset_out_n)
        else $error("secondary reset not asserted");
    a_mask_load_window: assert property (
        s_pri_release |-> !o_secondary_reset_out_n [*8])
        else $error("secondary reset released before mask load");
    a_gpio_oe_off: assert property (
        !i_primary_reset_n && i_clk_en |=> o_gpio_oe == '0)
        else $error("gpio driven in primary reset");
    // ==========
    // Arbiter, power, TAP
    a_arb_mode_sel: assert property (
        o_external_arbiter == i_arbiter_select_n)
        else $error("arbiter mode wrong");
    a_ext_arb_swap: assert property (
        i_arbiter_select_n |-> o_external_grant_n == i_downstream_request_zero_n
        && o_downstream_grant_zero_n == i_bridge_request_n)
        else $error("external arbiter pins wrong");
    a_b2_entry: assert property (
        i_clk_en && i_bus_power_clock_ctrl_en && i_power_state_d3hot |=> o_bus_b2)
        else $error("b2 not entered");
    a_b2_clk_low: assert property (
        o_bus_b2 |-> o_secondary_clock == '0)
        else $error("clock running in b2");
    a_tap_reset: assert property (
        !i_test_reset_n |=> !o_test_data_out_en)
        else $error("tap not reset");
endmodule : brsc_top_asserts
bind brsc_top brsc_top_asserts #(.CLK_NUM(CLK_NUM), .GPIO_W(GPIO_W)) u_chk (.*);
`default_nettype wire

/* File: testbench/brsc_ee_model.sv */
// Purpose: Serial EEPROM data pin model
// Assumes: No pull on the pin
// Notes:   Released pin shows inverse of last level
`default_nettype none
module brsc_ee_model (
    // Pins
    input  wire logic i_sys_clk,
    input  wire logic i_dev_o,
    input  wire logic i_dev_oe,
    input  wire logic i_drive,
    input  wire logic i_bit,
    output logic      o_io
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_q = 1'h0;
    always_comb o_io = i_dev_oe ? i_dev_o : (i_drive ? i_bit : ~last_q);
    always_ff @(posedge i_sys_clk) last_q <= o_io;
endmodule : brsc_ee_model
`default_nettype wire

/* File: testbench/brsc_top_tb.sv */
// Purpose: Directed bench of the reset/strap block
// Assumes: Drive on rising edge, sample on falling
// Notes:   Config reads wait a bounded time for valid
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module brsc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk = 1'h0, i_reset = 1'h1, i_clk_en = 1'h1, i_cfg_wr = 1'h0;
    logic i_primary_reset_n = 1'h0, i_primary_outputs_drive = 1'h1;
    logic i_upstream_system_error_req = 1'h1, i_primary_grant_drive = 1'h1;
    logic i_cfg_rd = 1'h0, i_arbiter_select_n = 1'h0;
    logic i_bridge_request_n = 1'h1;
    logic [7:0] i_cfg_addr = 8'h00;
    logic [31:0] i_cfg_wdata = 32'h0, o_cfg_rdata, d;
    logic [3:0] i_cfg_be = 4'hF, i_gpio = 4'h0, o_gpio, o_gpio_oe;
    logic i_downstream_request_zero_n = 1'h1, i_internal_grant_zero_n = 1'h1;
    logic i_upstream_66mhz_strap = 1'h0, i_bus_power_clock_ctrl_en = 1'h0;
    logic i_power_state_d3hot = 1'h0, i_secondary_clock_src = 1'h1;
    logic i_clock_disable_serial_in = 1'h0, i_eeprom_use_enable_n = 1'h1;
    logic i_ee_autoload_active = 1'h0, i_ee_vpd_active = 1'h0, pe_bit = 1'h0;
    logic i_ee_data_drive = 1'h0, i_ee_data_out = 1'h0, pe_drive = 1'h0;
    logic i_test_reset_n = 1'h0, i_test_clock = 1'h0, i_test_mode_select = 1'h0;
    logic i_test_data_in = 1'h0, i_eeprom_serial_io, o_secondary_reset_out_n;
    logic o_header_defaults_load, o_primary_outputs_oe, o_primary_grant_oe;
    logic o_upstream_system_error_n_o, o_upstream_system_error_n_oe;
    logic o_cfg_rvalid, o_downstream_grant_zero_n, o_external_arbiter;
    logic o_internal_request_zero_n, o_external_grant_n, o_bus_b2;
    logic [9:0] o_secondary_clock, o_secondary_clock_en;
    logic o_eeprom_serial_clock, o_eeprom_serial_io_o, o_eeprom_serial_io_oe;
    logic o_ee_data_in, o_eeprom_enabled, o_test_data_out, o_test_data_out_en;
    int n_fail = 0, tests_run = 0, k;
    localparam logic [9:0] M = 10'h205;
    brsc_top #(.CLK_NUM(10), .GPIO_W(4)) DUT (.*);
    brsc_ee_model u_ee (.i_sys_clk(i_sys_clk), .i_dev_o(o_eeprom_serial_io_o),
        .i_dev_oe(o_eeprom_serial_io_oe), .i_drive(pe_drive), .i_bit(pe_bit),
        .o_io(i_eeprom_serial_io));
    initial begin
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    // ==========
    // Tasks
    task automatic nx(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask : nx
    task automatic complete_run();
        if (n_fail == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    task automatic cfg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_sys_clk);
        i_cfg_wr <= 1'h1;
        i_cfg_addr <= a;
        i_cfg_wdata <= v;
        @(posedge i_sys_clk);
        i_cfg_wr <= 1'h0;
    endtask : cfg_wr
    task automatic cfg_rd(input logic [7:0] a, output logic [31:0] v);
        int j;
        @(posedge i_sys_clk);
        i_cfg_rd <= 1'h1;
        i_cfg_addr <= a;
        @(posedge i_sys_clk);
        i_cfg_rd <= 1'h0;
        for (j = 0; j < 4 && o_cfg_rvalid !== 1'h1; j++) nx(1);
        if (j == 4) begin
            n_fail++;
            complete_run();
        end
        v = o_cfg_rdata;
    endtask : cfg_rd
    // Primary release, mask stream LSB first
    task automatic rel(input logic [9:0] m);
        @(posedge i_sys_clk);
        i_primary_reset_n <= 1'h1;
        for (int b = 0; b < 10; b++) begin
            i_clock_disable_serial_in <= m[b];
            @(posedge i_sys_clk);
        end
    endtask : rel
    task automatic tck(input logic tms, input logic tdi);
        @(posedge i_sys_clk);
        i_test_mode_select <= tms;
        i_test_data_in <= tdi;
        repeat (2) @(posedge i_sys_clk);
        i_test_clock <= 1'h1;
        repeat (4) @(posedge i_sys_clk);
        i_test_clock <= 1'h0;
        repeat (4) @(posedge i_sys_clk);
    endtask : tck
    // ==========
    // Sequence
    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_reset <= 1'h0;
        i_test_reset_n <= 1'h1;
        nx(1);
        `CHK({o_secondary_reset_out_n, o_primary_outputs_oe}, 2'h0)
        `CHK({o_upstream_system_error_n_oe, o_primary_grant_oe}, 2'h0)
        `CHK(o_header_defaults_load, 1'h1)
        rel(M);
        nx(2);
        `CHK(o_secondary_reset_out_n, 1'h1)
        `CHK(o_secondary_clock_en, ~M)
        `CHK({o_primary_grant_oe, o_upstream_system_error_n_oe}, 2'h3)
        `CHK({o_primary_outputs_oe, o_upstream_system_error_n_o}, 2'h2)
        cfg_wr(8'h64, 32'h0000_050A);
        nx(1);
        `CHK({o_gpio_oe, o_gpio}, 8'hA5)
        @(posedge i_sys_clk);
        i_gpio <= 4'h3;
        cfg_rd(8'h64, d);
        `CHK(d[19:16], 4'h3)
        cfg_wr(8'h3C, 32'h0040_0000);
        nx(1);
        `CHK(o_secondary_reset_out_n, 1'h0)
        cfg_rd(8'h3C, d);
        `CHK(d[22], 1'h1)
        @(posedge i_sys_clk);
        i_primary_reset_n <= 1'h0;
        nx(2);
        `CHK(o_gpio_oe, 4'h0)
        rel(M);
        nx(2);
        `CHK(o_secondary_reset_out_n, 1'h1)
        cfg_rd(8'h3C, d);
        `CHK(d, 32'h0)
        for (int v = 0; v < 2; v++) begin
            @(posedge i_sys_clk);
            i_upstream_66mhz_strap <= v[0];
            cfg_rd(8'h1C, d);
            `CHK(d[21], v[0])
        end
        for (int s = 0; s < 4; s++) begin
            @(posedge i_sys_clk);
            i_arbiter_select_n <= s[1];
            {i_downstream_request_zero_n, i_internal_grant_zero_n} <= {2{s[0]}};
            i_bridge_request_n <= ~s[0];
            nx(1);
            `CHK(o_external_arbiter, s[1])
            `CHK(o_downstream_grant_zero_n, s[1] ? ~s[0] : s[0])
            `CHK({o_external_grant_n, o_internal_request_zero_n},
                 {~s[1] | s[0], s[1] | s[0]})
        end
        @(posedge i_sys_clk);
        {i_bus_power_clock_ctrl_en, i_power_state_d3hot} <= 2'h3;
        nx(2);
        `CHK({o_bus_b2, o_secondary_clock}, 11'h400)
        @(posedge i_sys_clk);
        i_bus_power_clock_ctrl_en <= 1'h0;
        nx(2);
        `CHK(o_secondary_clock, ~M)
        @(posedge i_sys_clk);
        i_ee_autoload_active <= 1'h1;
        nx(130);
        `CHK({o_eeprom_serial_clock, o_eeprom_enabled}, 2'h0)
        @(posedge i_sys_clk);
        i_eeprom_use_enable_n <= 1'h0;
        for (k = 0; k < 140 && o_eeprom_serial_clock !== 1'h1; k++) nx(1);
        `CHK(k > 120 && k < 130, 1'h1)
        @(posedge i_sys_clk);
        {i_ee_autoload_active, i_ee_vpd_active} <= 2'h1;
        for (k = 0; k < 140 && o_eeprom_serial_clock !== 1'h0; k++) nx(1);
        `CHK(k < 140, 1'h1)
        @(posedge i_sys_clk);
        {i_ee_data_drive, i_ee_data_out} <= 2'h3;
        nx(2);
        `CHK({o_eeprom_serial_io_oe, o_ee_data_in, o_eeprom_enabled}, 3'h7)
        `CHK(o_eeprom_serial_io_o, 1'h1)
        @(posedge i_sys_clk);
        {i_ee_data_drive, pe_drive} <= 2'h1;
        nx(3);
        `CHK(o_ee_data_in, 1'h0)
        tck(1'h0, 1'h0);
        tck(1'h1, 1'h0);
        tck(1'h0, 1'h0);
        tck(1'h0, 1'h0);
        nx(1);
        `CHK({o_test_data_out_en, o_test_data_out}, 2'h2)
        tck(1'h0, 1'h1);
        nx(1);
        `CHK(o_test_data_out, 1'h1)
        @(posedge i_sys_clk);
        i_test_reset_n <= 1'h0;
        nx(2);
        `CHK(o_test_data_out_en, 1'h0)
        complete_run();
    end
endmodule : brsc_top_tb
`default_nettype wire
